/* design/pcsc_cfg_regs.v */
// Status, command-enable and class/revision configuration registers of the endpoint
// Overview of operation
// - Poisoned packet received sets bit 15 always
// - Error message sent with error enable sets 14
// - Unsupported-request completion received sets bit 13
// - Completer-abort completion received sets bit 12
// - Completing request with abort sets bit 11
// - Select-timing bits 10:9 read zero
// - Poisoned data with parity enable sets 8
// - Bit 7 back-to-back capable reads zero
// - Bit 5 fast-clock capable reads zero
// - Reserved bits 6 and 2:0 read zero
// - Bit 4 capability chain reads one
// - Bit 3 tracks pending legacy interrupt
// - Class bytes 0c, 03, 30 read-only
// - Low byte is fixed revision identifier
// - Command bit 6 parity enable, resets zero
// - Command bit 8 error enable, resets zero
`timescale 1ns/1ps
`include "pcsc_defs.vh"
module pcsc_cfg_regs #(
  parameter [7:0] REVISION_ID = 8'h01 // Arbitrary value
) (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rstn,
  // Configuration request
  input  wire        cfg_wr,
  input  wire        cfg_rd,
  input  wire [7:0]  cfg_addr,
  input  wire [3:0]  cfg_be,
  input  wire [31:0] cfg_wdata,
  // Configuration answer
  output reg  [31:0] cfg_rdata_q,
  output reg         cfg_rvalid_q,
  output reg         cfg_unmapped_q,
  // Link events, one-cycle pulses
  input  wire        poisoned_rx_pulse,
  input  wire        error_msg_sent_pulse,
  input  wire        ur_completion_pulse,
  input  wire        ca_completion_pulse,
  input  wire        ca_signalled_pulse,
  input  wire        poisoned_cpl_data_pulse,
  input  wire        poisoned_write_pulse,
  // Function state
  input  wire        intx_pending,
  // Enables to the rest of the function
  output wire        parity_response_enable,
  output wire        error_report_enable
);
  reg         perr_en_q;
  reg         serr_en_q;
  wire [5:0]  flags;
  wire [5:0]  set_vec;
  wire [5:0]  clr_vec;
  wire [15:0] sts_image;
  wire [15:0] cmd_image;
  wire [31:0] class_image;
  wire [31:0] rd_word;
  wire        rd_hit;
  wire        wr_sts;
  wire        wr_cmd;
  wire [15:0] sts_wdata;

  assign parity_response_enable = perr_en_q;
  assign error_report_enable    = serr_en_q;

  // Command word at 04h: status shares the dword in its upper half
  assign wr_cmd    = cfg_wr && (cfg_addr == `PCSC_CMD_OFS);
  assign wr_sts    = cfg_wr && ((cfg_addr == `PCSC_CMD_OFS) || (cfg_addr == `PCSC_STS_OFS));
  assign sts_wdata = (cfg_addr == `PCSC_CMD_OFS) ?
                     ({cfg_be[3] ? cfg_wdata[31:24] : 8'h00, cfg_be[2] ? cfg_wdata[23:16] : 8'h00}) :
                     ({cfg_be[1] ? cfg_wdata[15:8] : 8'h00, cfg_be[0] ? cfg_wdata[7:0] : 8'h00});

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      perr_en_q <= 1'b0;
      serr_en_q <= 1'b0;
    end else if (wr_cmd) begin
      if (cfg_be[0]) begin
        perr_en_q <= cfg_wdata[`PCSC_CMD_PERR_BIT];
      end
      if (cfg_be[1]) begin
        serr_en_q <= cfg_wdata[`PCSC_CMD_SERR_BIT];
      end
    end
  end

  // Flag order: 15,14,13,12,11,8
  assign set_vec[5] = poisoned_rx_pulse;
  assign set_vec[4] = error_msg_sent_pulse && serr_en_q;
  assign set_vec[3] = ur_completion_pulse;
  assign set_vec[2] = ca_completion_pulse;
  assign set_vec[1] = ca_signalled_pulse;
  assign set_vec[0] = perr_en_q && (poisoned_cpl_data_pulse || poisoned_write_pulse);

  assign clr_vec = wr_sts ? {sts_wdata[`PCSC_STS_POISON_BIT], sts_wdata[`PCSC_STS_ERRMSG_BIT],
                             sts_wdata[`PCSC_STS_UR_BIT], sts_wdata[`PCSC_STS_CAR_BIT],
                             sts_wdata[`PCSC_STS_CAS_BIT], sts_wdata[`PCSC_STS_DPAR_BIT]} : 6'h00;

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_flag
      pcsc_sticky_bit u_flag (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .set_pulse (set_vec[gi]),
        .clr_pulse (clr_vec[gi]),
        .flag_q    (flags[gi])
      );
    end
  endgenerate

  // Constant bits folded in; interrupt bit is live, not latched
  assign sts_image = {flags[5:1], 2'b00, flags[0], 1'b0, 1'b0, 1'b0,
                      1'b1, intx_pending, 3'b000};
  assign cmd_image = (`PCSC_CMD_RESET) | ({7'h00, serr_en_q, 1'b0, perr_en_q, 6'h00});
  assign class_image = {`PCSC_BASE_CLASS, `PCSC_SUB_CLASS, `PCSC_PROG_IF, REVISION_ID};

  pcsc_rd_mux u_mux (
    .cfg_addr    (cfg_addr),
    .cmd_image   (cmd_image),
    .sts_image   (sts_image),
    .class_image (class_image),
    .rd_word     (rd_word),
    .rd_hit      (rd_hit)
  );

  // Registered answer, one cycle after the request; unmapped reads return zero
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_rdata_q    <= 32'h0000_0000;
      cfg_rvalid_q   <= 1'b0;
      cfg_unmapped_q <= 1'b0;
    end else begin
      cfg_rvalid_q   <= cfg_rd;
      cfg_unmapped_q <= (cfg_rd || cfg_wr) && !rd_hit;
      cfg_rdata_q    <= cfg_rd ? rd_word : 32'h0000_0000;
    end
  end
endmodule

/* design/pcsc_defs.vh */
// Offsets, field positions and constant values of the status and class registers
`ifndef PCSC_DEFS_VH
`define PCSC_DEFS_VH
`define PCSC_CMD_OFS        8'h04
`define PCSC_STS_OFS        8'h06
`define PCSC_CLASS_OFS      8'h08
`define PCSC_CMD_PERR_BIT   6
`define PCSC_CMD_SERR_BIT   8
`define PCSC_STS_POISON_BIT 15
`define PCSC_STS_ERRMSG_BIT 14
`define PCSC_STS_UR_BIT     13
`define PCSC_STS_CAR_BIT    12
`define PCSC_STS_CAS_BIT    11
`define PCSC_STS_DPAR_BIT   8
`define PCSC_STS_CAP_BIT    4
`define PCSC_STS_INT_BIT    3
`define PCSC_STS_RESET      16'h0010
`define PCSC_CMD_RESET      16'h0000
`define PCSC_BASE_CLASS     8'h0c
`define PCSC_SUB_CLASS      8'h03
`define PCSC_PROG_IF        8'h30
`endif

/* design/pcsc_rd_mux.v */
// Configuration read data mux for command, status and class registers
`timescale 1ns/1ps
`include "pcsc_defs.vh"
module pcsc_rd_mux (
  // Address
  input  wire [7:0]  cfg_addr,
  // Register images
  input  wire [15:0] cmd_image,
  input  wire [15:0] sts_image,
  input  wire [31:0] class_image,
  // Result
  output reg  [31:0] rd_word,
  output reg         rd_hit
);
  always @* begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (cfg_addr == `PCSC_CMD_OFS) begin
      rd_word = {sts_image, cmd_image};
    end else if (cfg_addr == `PCSC_STS_OFS) begin
      rd_word = {16'h0000, sts_image};
    end else if (cfg_addr == `PCSC_CLASS_OFS) begin
      rd_word = class_image;
    end else begin
      rd_hit = 1'b0;
    end
  end
endmodule

/* design/pcsc_sticky_bit.v */
// One sticky error flag: hardware set, write-one-to-clear, set wins
`timescale 1ns/1ps
module pcsc_sticky_bit (
  // Clock and reset
  input  wire sys_clk,
  input  wire rstn,
  // Set and clear
  input  wire set_pulse,
  input  wire clr_pulse,
  // Flag
  output reg  flag_q
);
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      flag_q <= 1'b0;
    end else if (set_pulse) begin
      flag_q <= 1'b1;
    end else if (clr_pulse) begin
      flag_q <= 1'b0;
    end
  end
endmodule

/* tb/pcie_cfg_status_and_class_tb.sv */
// Self-checking bench for the status and class registers
`timescale 1ns/1ps
module pcie_cfg_status_and_class_tb;
  reg         sys_clk = 1'b0;
  reg         rstn = 1'b0;
  reg         intx_pending = 1'b0;
  reg  [6:0]  ev = 7'h0;
  reg  [31:0] m;
  reg  [32:0] exp_q[$];
  integer     n_errors = 0, n_tests = 0, cyc = 0;
  wire        cfg_wr, cfg_rd, cfg_rvalid_q, cfg_unmapped_q, parity_response_enable, error_report_enable;
  wire [7:0]  cfg_addr;
  wire [3:0]  cfg_be;
  wire [31:0] cfg_wdata, cfg_rdata_q;
  wire poisoned_rx_pulse = ev[6], error_msg_sent_pulse = ev[5], ur_completion_pulse = ev[4];
  wire ca_completion_pulse = ev[3], ca_signalled_pulse = ev[2], poisoned_cpl_data_pulse = ev[1];
  wire poisoned_write_pulse = ev[0];
  initial forever #2.5 sys_clk = ~sys_clk;
  pcsc_rc_model i_rc (.*);
  pcsc_cfg_regs #(.REVISION_ID(8'h5a)) i_dut (.*);
  task chk(input [32:0] seen, input [32:0] want);
    n_tests = n_tests + 1;
    if (seen !== want) begin
      n_errors = n_errors + 1;
      $display("Error at %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    reg iv;
    iv = $urandom;
    exp_q.push_back({a == 8'h40, e | (a == 8'h06 ? iv << 3 : a == 8'h04 ? iv << 19 : 0)});
    intx_pending <= iv;
    i_rc.req(0, 1, a, 4'hf, 32'h0);
  endtask
  task pulse(input [6:0] x);
    @(posedge sys_clk);
    ev <= x;
    @(posedge sys_clk);
    ev <= 7'h0;
  endtask
  task report_and_stop;
    $display("Errors %0d in %0d checks", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 500) begin
      n_errors = n_errors + 1;
      report_and_stop;
    end
    if (cfg_rvalid_q === 1'b1)
      chk({cfg_unmapped_q, cfg_rdata_q}, exp_q.pop_front());
  end
  initial begin
    m = $urandom(32'h262d);
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(8'h06, 32'h10);
    i_rc.req(1, 0, 8'h08, 4'hf, 32'h0);
    rd(8'h08, 32'h0c03305a);
    rd(8'h40, 32'h0);
    i_rc.req(1, 0, 8'h04, 4'h3, 32'hffff);
    pulse(7'h7f);
    rd(8'h04, 32'hf9100140);
    m = $urandom & 32'hffff;
    fork
      pulse(7'h40);
      i_rc.req(1, 0, 8'h06, 4'h3, m);
    join
    rd(8'h06, 32'hf910 & ~m | 32'h8010);
    i_rc.req(1, 0, 8'h04, 4'hf, 32'hffff0000);
    pulse(7'h21);
    rd(8'h06, 32'h10);
    pulse(7'h7f);
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(8'h04, 32'h100000);
    repeat (3) @(posedge sys_clk);
    report_and_stop;
  end
endmodule

/* tb/pcsc_props.sv */
// Assertion checker for the status and class registers
`timescale 1ns/1ps
module pcsc_props (
  // Clock and reset
  input wire        sys_clk,
  input wire        rstn,
  // Requests and answers
  input wire        cfg_rd,
  input wire        cfg_wr,
  input wire [7:0]  cfg_addr,
  input wire [3:0]  cfg_be,
  input wire [31:0] cfg_wdata,
  input wire [31:0] cfg_rdata_q,
  input wire        cfg_rvalid_q,
  // Events and enables
  input wire        poisoned_rx_pulse,
  input wire        ur_completion_pulse,
  input wire        intx_pending,
  input wire        parity_response_enable,
  input wire        error_report_enable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire rs = cfg_rd && cfg_addr == 8'h06;
  wire w4 = cfg_wr && cfg_addr == 8'h04;
  property p_lat; cfg_rd |=> cfg_rvalid_q; endproperty
  a_lat: assert property (p_lat) else $error("read answer late");
  property p_zero; rs |=> (cfg_rdata_q & 32'hffff06e7) == 32'h0; endproperty
  a_zero: assert property (p_zero) else $error("constant zero bit set");
  property p_cap; rs |=> cfg_rdata_q[4]; endproperty
  a_cap: assert property (p_cap) else $error("chain bit low");
  property p_int; rs |=> cfg_rdata_q[3] == $past(intx_pending); endproperty
  a_int: assert property (p_int) else $error("interrupt bit stale");
  property p_cls; cfg_rd && cfg_addr == 8'h08 |=> cfg_rdata_q[31:8] == 24'h0c0330; endproperty
  a_cls: assert property (p_cls) else $error("class bytes wrong");
  // Set wins over a clear in the same cycle, so a write beside the pulse is allowed
  property p_poi; poisoned_rx_pulse ##1 !cfg_wr ##1 rs |=> cfg_rdata_q[15]; endproperty
  a_poi: assert property (p_poi) else $error("poison flag missed");
  property p_ur; ur_completion_pulse ##1 !cfg_wr ##1 (cfg_rd && cfg_addr == 8'h04) |=> cfg_rdata_q[29]; endproperty
  a_ur: assert property (p_ur) else $error("request flag missed");
  property p_pe; w4 && cfg_be[0] |=> parity_response_enable == $past(cfg_wdata[6]); endproperty
  a_pe: assert property (p_pe) else $error("parity enable wrong");
  property p_se; w4 && cfg_be[1] |=> error_report_enable == $past(cfg_wdata[8]); endproperty
  a_se: assert property (p_se) else $error("report enable wrong");
  c_poi: cover property (poisoned_rx_pulse && cfg_wr);
  c_pe: cover property (w4);
  c_cls: cover property (cfg_rd && cfg_addr == 8'h08);
endmodule
bind pcsc_cfg_regs pcsc_props i_props (.*);

/* tb/pcsc_rc_model.sv */
// Root complex model issuing configuration requests
`timescale 1ns/1ps
module pcsc_rc_model (
  // Clock
  input wire        sys_clk,
  // Requests
  output reg        cfg_wr,
  output reg        cfg_rd,
  output reg [7:0]  cfg_addr,
  output reg [3:0]  cfg_be,
  output reg [31:0] cfg_wdata
);
  initial {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = 46'h0;
  // Idle strobes clear and address, enables and data flip so a stale value never looks like a request
  task req(input w, input r, input [7:0] a, input [3:0] b, input [31:0] d);
    @(posedge sys_clk);
    {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} <= {w, r, a, b, d};
    @(posedge sys_clk);
    {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} <= {2'b00, ~a, ~b, ~d};
  endtask
endmodule
